// ===== design/uart_modes_consts.svh
// constants of the asynchronous serial channel: field codes and timing counts
`ifndef UART_MODES_CONSTS_SVH
`define UART_MODES_CONSTS_SVH
// frame format select codes
`define FMT_SYNC 2'h0
`define FMT_7BIT 2'h1
`define FMT_8BIT 2'h2
`define FMT_9BIT 2'h3
// default bit time in clock cycles
`define BIT_CYCLES 16'h00AD
// line idle level
`define LINE_IDLE 1'h1
`endif

// ===== design/uart_modes_pkg.sv
// types shared by the serial channel modules
package uart_modes_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_EXTRA, ST_STOP} phase_e;
endpackage : uart_modes_pkg

// ===== design/uart_frame_if.sv
// frame settings shared by transmitter and receiver
`timescale 1ns/10ps
interface uart_frame_if;
  logic [3:0] data_bits; // character length excluding ninth bit
  logic has_extra; // parity or ninth bit slot present
  logic ninth_mode; // extra slot carries ninth bit
  logic odd; // odd parity selected
  logic two_stop; // two stop bits
  logic [15:0] bit_cycles; // cycles per bit
  modport src (output data_bits, has_extra, ninth_mode, odd, two_stop, bit_cycles);
  modport snk (input data_bits, has_extra, ninth_mode, odd, two_stop, bit_cycles);
endinterface : uart_frame_if

// ===== design/uart_tx.sv
// transmit serialiser
`timescale 1ns/10ps
`include "uart_modes_consts.svh"
module uart_tx (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // frame settings
  uart_frame_if.snk cfg,
  // character in
  input wire logic start,
  input wire logic [8:0] data,
  // line and status
  output logic txd,
  output logic busy
);
  typedef struct packed {
    uart_modes_pkg::phase_e ph;
    logic [15:0] cnt; // cycles left in bit
    logic [3:0] idx; // bit index
    logic [8:0] sh; // character being sent
    logic stop2; // second stop pending
    logic txd;
  } tx_s;
  tx_s q, next_q;
  logic par; // computed parity bit

  // parity over data bits only
  always_comb begin
    par = cfg.odd;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < cfg.data_bits) begin
        par = par ^ q.sh[i];
      end
    end
  end

  // bit sequencing
  always_comb begin
    next_q = q;
    if (q.ph != uart_modes_pkg::ST_IDLE) begin
      next_q.cnt = q.cnt - 16'h0001;
    end
    case (q.ph)
      uart_modes_pkg::ST_IDLE: begin
        next_q.txd = `LINE_IDLE;
        if (start) begin
          next_q.ph = uart_modes_pkg::ST_START;
          next_q.sh = data;
          next_q.txd = 1'h0;
          next_q.cnt = cfg.bit_cycles;
        end
      end
      uart_modes_pkg::ST_START, uart_modes_pkg::ST_DATA: begin
        if (q.cnt == 16'h0001) begin
          next_q.cnt = cfg.bit_cycles;
          if (q.ph == uart_modes_pkg::ST_START) begin
            next_q.idx = 4'h0;
          end else begin
            next_q.idx = q.idx + 4'h1;
          end
          if (q.ph == uart_modes_pkg::ST_START || q.idx + 4'h1 < cfg.data_bits) begin
            next_q.ph = uart_modes_pkg::ST_DATA;
            next_q.txd = q.sh[next_q.idx];
          end else if (cfg.has_extra) begin
            next_q.ph = uart_modes_pkg::ST_EXTRA;
            next_q.txd = cfg.ninth_mode ? q.sh[8] : par;
          end else begin
            next_q.ph = uart_modes_pkg::ST_STOP;
            next_q.txd = 1'h1;
            next_q.stop2 = cfg.two_stop;
          end
        end
      end
      uart_modes_pkg::ST_EXTRA: begin
        if (q.cnt == 16'h0001) begin
          next_q.ph = uart_modes_pkg::ST_STOP;
          next_q.txd = 1'h1;
          next_q.cnt = cfg.bit_cycles;
          next_q.stop2 = cfg.two_stop;
        end
      end
      uart_modes_pkg::ST_STOP: begin
        if (q.cnt == 16'h0001) begin
          next_q.cnt = cfg.bit_cycles;
          if (q.stop2) begin
            next_q.stop2 = 1'h0;
          end else begin
            next_q.ph = uart_modes_pkg::ST_IDLE;
          end
        end
      end
      default: next_q.ph = uart_modes_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{ph: uart_modes_pkg::ST_IDLE, cnt: 16'h0000, idx: 4'h0, sh: 9'h000,
             stop2: 1'h0, txd: 1'h1};
    end else begin
      q <= next_q;
    end
  end

  assign txd = q.txd;
  assign busy = (q.ph != uart_modes_pkg::ST_IDLE);

  // line idles high when nothing is sent
  a_idle_high: assert property (@(posedge clk) disable iff (rst)
    !busy |-> txd) else $error("line not high while idle");
  // start bit follows a start request
  a_start_low: assert property (@(posedge clk) disable iff (rst)
    (!busy && start) |=> (!txd && busy)) else $error("no start bit");
  c_tx_frame: cover property (@(posedge clk) disable iff (rst) !busy && start);
endmodule : uart_tx

// ===== design/uart_rx.sv
// receive deserialiser with parity and ninth bit capture
`timescale 1ns/10ps
`include "uart_modes_consts.svh"
module uart_rx (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // frame settings
  uart_frame_if.snk cfg,
  // synchronised line
  input wire logic rxd,
  // character out
  output logic done,
  output logic [7:0] data,
  output logic ninth,
  output logic perr,
  output logic ferr
);
  typedef struct packed {
    uart_modes_pkg::phase_e ph;
    logic [15:0] cnt;
    logic [3:0] idx;
    logic [7:0] sh;
    logic ext; // sampled extra bit
    logic done;
    logic perr;
    logic ferr;
  } rx_s;
  rx_s q, next_q;
  logic par; // expected parity
  logic ext_par; // sampled extra bit, seen by the parity assertion
  assign ext_par = q.ext;

  // expected parity over the received data
  always_comb begin
    par = cfg.odd;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < cfg.data_bits) begin
        par = par ^ q.sh[i];
      end
    end
  end

  // sampling at mid-bit
  always_comb begin
    next_q = q;
    next_q.done = 1'h0;
    if (q.ph != uart_modes_pkg::ST_IDLE) begin
      next_q.cnt = q.cnt - 16'h0001;
    end
    case (q.ph)
      uart_modes_pkg::ST_IDLE: begin
        if (!rxd) begin
          next_q.ph = uart_modes_pkg::ST_START;
          next_q.cnt = {1'h0, cfg.bit_cycles[15:1]};
        end
      end
      uart_modes_pkg::ST_START: begin
        if (q.cnt == 16'h0001) begin
          // false start if line back high
          next_q.ph = rxd ? uart_modes_pkg::ST_IDLE : uart_modes_pkg::ST_DATA;
          next_q.cnt = cfg.bit_cycles;
          next_q.idx = 4'h0;
          next_q.sh = 8'h00;
        end
      end
      uart_modes_pkg::ST_DATA: begin
        if (q.cnt == 16'h0001) begin
          next_q.cnt = cfg.bit_cycles;
          next_q.sh[q.idx[2:0]] = rxd;
          next_q.idx = q.idx + 4'h1;
          if (q.idx + 4'h1 >= cfg.data_bits) begin
            next_q.ph = cfg.has_extra ? uart_modes_pkg::ST_EXTRA : uart_modes_pkg::ST_STOP;
          end
        end
      end
      uart_modes_pkg::ST_EXTRA: begin
        if (q.cnt == 16'h0001) begin
          next_q.cnt = cfg.bit_cycles;
          next_q.ext = rxd;
          next_q.ph = uart_modes_pkg::ST_STOP;
        end
      end
      uart_modes_pkg::ST_STOP: begin
        if (q.cnt == 16'h0001) begin
          next_q.ph = uart_modes_pkg::ST_IDLE;
          next_q.done = 1'h1;
          next_q.ferr = !rxd;
          next_q.perr = cfg.has_extra && !cfg.ninth_mode && (q.ext != par);
        end
      end
      default: next_q.ph = uart_modes_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{ph: uart_modes_pkg::ST_IDLE, cnt: 16'h0000, idx: 4'h0, sh: 8'h00,
             ext: 1'h0, done: 1'h0, perr: 1'h0, ferr: 1'h0};
    end else begin
      q <= next_q;
    end
  end

  assign done = q.done;
  assign data = q.sh;
  assign ninth = cfg.ninth_mode & q.ext;
  assign perr = q.perr;
  assign ferr = q.ferr;

  // flag against a reduction parity of buffer, polarity and extra bit
  a_perr_parity: assert property (@(posedge clk) disable iff (rst)
    done |-> (perr == (cfg.has_extra && !cfg.ninth_mode && (ext_par ^ cfg.odd ^ (^q.sh)))))
    else $error("parity error flag wrong");
  c_rx_done: cover property (@(posedge clk) disable iff (rst) done);
  c_rx_perr: cover property (@(posedge clk) disable iff (rst) done && perr);
endmodule : uart_rx

// ===== design/uart_modes.sv
// asynchronous serial channel: 7, 8 and 9-bit modes with wakeup filter
`timescale 1ns/10ps
`include "uart_modes_consts.svh"
module uart_modes #(
  parameter logic [15:0] BIT_CYCLES = `BIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire logic [1:0] frame_format_select,
  input wire logic parity_enable,
  input wire logic odd_parity,
  input wire logic stop_bit_length,
  input wire logic wakeup_filter_enable,
  input wire logic transmit_ninth_bit,
  // transmit data buffer write
  input wire logic tx_write,
  input wire logic [7:0] tx_data,
  // serial pins
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  output logic serial_transmit_oe,
  // receive side
  output logic [7:0] serial_data_buffer,
  output logic received_ninth_bit,
  output logic parity_error,
  output logic framing_error,
  output logic receive_interrupt,
  // status
  output logic tx_busy
);
  uart_frame_if cfg ();
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_ninth;
  logic rx_perr;
  logic rx_ferr;
  logic line_txd;
  logic line_busy;
  logic async_mode; // any uart mode selected

  typedef struct packed {
    logic sync1; // first synchroniser stage
    logic sync2; // second synchroniser stage
    logic pend; // write waiting for idle transmitter
    logic [8:0] tbuf; // pending character
    logic start;
    logic txd;
    logic oe;
    logic busy;
    logic [7:0] rbuf;
    logic rb8;
    logic perr;
    logic ferr;
    logic irq;
  } top_s;
  top_s q, next_q;

  assign async_mode = (frame_format_select != `FMT_SYNC);

  // frame shape from the mode fields
  always_comb begin
    cfg.bit_cycles = BIT_CYCLES;
    cfg.odd = odd_parity; // polarity choice
    cfg.two_stop = stop_bit_length; // stop length
    cfg.ninth_mode = 1'h0;
    cfg.data_bits = 4'h8;
    cfg.has_extra = 1'h0;
    case (frame_format_select)
      `FMT_7BIT: begin
        cfg.data_bits = 4'h7;
        cfg.has_extra = parity_enable;
      end
      `FMT_8BIT: begin
        cfg.has_extra = parity_enable;
      end
      `FMT_9BIT: begin
        cfg.has_extra = 1'h1;
        cfg.ninth_mode = 1'h1;
      end
      default: cfg.data_bits = 4'h8;
    endcase
  end

  uart_tx u_tx (
    .clk(clk),
    .rst(rst),
    .cfg(cfg.snk),
    .start(q.start),
    .data(q.tbuf),
    .txd(line_txd),
    .busy(line_busy)
  );

  uart_rx u_rx (
    .clk(clk),
    .rst(rst),
    .cfg(cfg.snk),
    .rxd(q.sync2),
    .done(rx_done),
    .data(rx_data),
    .ninth(rx_ninth),
    .perr(rx_perr),
    .ferr(rx_ferr)
  );

  // buffers, wakeup filter and pin drive
  always_comb begin
    next_q = q;
    next_q.sync1 = serial_receive_pin;
    next_q.sync2 = q.sync1;
    next_q.start = 1'h0;
    next_q.irq = 1'h0;
    // ninth bit sampled with the buffer write
    if (tx_write && async_mode) begin
      next_q.pend = 1'h1;
      next_q.tbuf = {transmit_ninth_bit, tx_data};
    end
    // hand over once the serialiser is idle
    if (q.pend && !line_busy && !q.start) begin
      next_q.start = 1'h1;
      next_q.pend = 1'h0;
    end
    next_q.busy = next_q.pend || next_q.start || line_busy;
    next_q.txd = line_txd;
    // open drain style: drive only low bits when filtering as slave
    next_q.oe = !(wakeup_filter_enable && frame_format_select == `FMT_9BIT) || !line_txd;
    if (rx_done && async_mode) begin
      next_q.rbuf = rx_data;
      next_q.rb8 = rx_ninth;
      next_q.perr = rx_perr;
      next_q.ferr = rx_ferr;
      if (!(wakeup_filter_enable && frame_format_select == `FMT_9BIT) || rx_ninth) begin
        next_q.irq = 1'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{sync1: 1'h1, sync2: 1'h1, pend: 1'h0, tbuf: 9'h000, start: 1'h0,
             txd: 1'h1, oe: 1'h1, busy: 1'h0, rbuf: 8'h00, rb8: 1'h0, perr: 1'h0,
             ferr: 1'h0, irq: 1'h0};
    end else begin
      q <= next_q;
    end
  end

  assign serial_transmit_pin = q.txd;
  assign serial_transmit_oe = q.oe;
  assign serial_data_buffer = q.rbuf;
  assign received_ninth_bit = q.rb8;
  assign parity_error = q.perr;
  assign framing_error = q.ferr;
  assign receive_interrupt = q.irq;
  assign tx_busy = q.busy;

  a_wakeup_filter: assert property (@(posedge clk) disable iff (rst)
    (rx_done && wakeup_filter_enable && frame_format_select == `FMT_9BIT && !rx_ninth)
    |=> !receive_interrupt) else $error("interrupt on data while filtering");
  a_irq_normal: assert property (@(posedge clk) disable iff (rst)
    (rx_done && async_mode && !wakeup_filter_enable) |=> receive_interrupt)
    else $error("missing receive interrupt");
  a_ninth_capture: assert property (@(posedge clk) disable iff (rst)
    (rx_done && async_mode) |=> (received_ninth_bit == $past(rx_ninth)))
    else $error("ninth bit not captured");
  a_write_starts: assert property (@(posedge clk) disable iff (rst)
    (tx_write && async_mode && !tx_busy && !q.pend) |-> ##[1:3] q.start)
    else $error("write did not start frame");
  c_wake_addr: cover property (@(posedge clk) disable iff (rst)
    receive_interrupt && received_ninth_bit);
endmodule : uart_modes

// ===== sim/uart_peer.sv
// peer serial port model on the far side of the channel
`timescale 1ns/10ps
module uart_peer #(
  parameter int BIT = 16
) (
  // clock
  input wire logic clk,
  // line from the device, after the pull-up
  input wire logic line_in,
  // line into the device
  output logic line_out
);
  // idle line is high
  initial line_out = 1'b1;

  // frame out
  // low start, then n bits lsb first, extra and stops already in v
  task automatic send(input int n, input logic [11:0] v);
    @(posedge clk);
    #5 line_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clk);
      #5 line_out = v[i];
    end
    repeat (BIT) @(posedge clk);
    // back to idle even after a bad stop bit
    #5 line_out = 1'b1;
  endtask : send

  // frame in
  // samples at mid-bit, so a few cycles of start jitter do no harm
  task automatic recv(input int n, output logic [11:0] v, output logic ok);
    int k;
    v = 12'hFFF;
    ok = 1'b0;
    for (k = 0; k < 200; k++) begin
      @(posedge clk);
      #1;
      if (!line_in) break;
    end
    repeat (BIT / 2) @(posedge clk);
    #1 ok = (line_in === 1'b0);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clk);
      #1 v[i] = line_in;
    end
  endtask : recv
endmodule : uart_peer

// ===== sim/uart_modes_tb.sv
// self-checking bench of the serial channel against a peer model
`timescale 1ns/10ps
module uart_modes_tb;
  localparam int BIT = 16; // short bit time keeps the run brief
  logic clk, rst;
  logic [1:0] frame_format_select;
  logic parity_enable, odd_parity, stop_bit_length;
  logic wakeup_filter_enable, transmit_ninth_bit;
  logic tx_write;
  logic [7:0] tx_data;
  logic serial_transmit_pin, serial_transmit_oe, line, rxd;
  logic [7:0] serial_data_buffer;
  logic received_ninth_bit, parity_error, framing_error;
  logic receive_interrupt, tx_busy;
  int errors, n_checks, irq_n, busy_cnt;

  assign line = serial_transmit_oe ? serial_transmit_pin : 1'b1;

  uart_modes #(.BIT_CYCLES(16'(BIT))) DUT (
    .clk(clk), .rst(rst),
    .frame_format_select(frame_format_select), .parity_enable(parity_enable),
    .odd_parity(odd_parity), .stop_bit_length(stop_bit_length),
    .wakeup_filter_enable(wakeup_filter_enable), .transmit_ninth_bit(transmit_ninth_bit),
    .tx_write(tx_write), .tx_data(tx_data), .serial_receive_pin(rxd),
    .serial_transmit_pin(serial_transmit_pin), .serial_transmit_oe(serial_transmit_oe),
    .serial_data_buffer(serial_data_buffer), .received_ninth_bit(received_ninth_bit),
    .parity_error(parity_error), .framing_error(framing_error),
    .receive_interrupt(receive_interrupt), .tx_busy(tx_busy)
  );
  uart_peer #(.BIT(BIT)) peer (.clk(clk), .line_in(line), .line_out(rxd));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // interrupt pulses and busy length counted apart from the tasks
  always @(posedge clk) begin
    if (receive_interrupt === 1'b1) irq_n <= irq_n + 1;
    if (tx_write) busy_cnt <= 0;
    else if (tx_busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // expected bits after the start bit, ones above the frame
  function automatic logic [11:0] fvec(input logic [1:0] f, input logic p, input logic o,
                                       input logic n, input logic [7:0] d);
    int db;
    logic par;
    logic [11:0] v;
    db = (f == 2'h1) ? 7 : 8;
    v = 12'hFFF;
    par = o;
    for (int i = 0; i < db; i++) begin
      v[i] = d[i];
      par = par ^ d[i];
    end
    if (f == 2'h3) v[db] = n;
    else if (p) v[db] = par;
    return v;
  endfunction : fvec

  function automatic int nbits(input logic [1:0] f, input logic p, input logic s);
    return ((f == 2'h1) ? 7 : 8) + int'((f == 2'h3) | p) + (s ? 2 : 1);
  endfunction : nbits

  task automatic set_cfg(input logic [1:0] f, input logic p, o, s, w);
    @(posedge clk);
    #5 frame_format_select = f;
    parity_enable = p;
    odd_parity = o;
    stop_bit_length = s;
    wakeup_filter_enable = w;
  endtask : set_cfg

  // one character out of the device, decoded by the peer
  task automatic tx_chk(input logic [1:0] f, input logic p, o, s, w, n, input logic [7:0] d);
    logic [11:0] got;
    logic ok;
    int nb;
    int span;
    nb = nbits(f, p, s);
    set_cfg(f, p, o, s, w);
    // ninth bit set before the buffer write
    transmit_ninth_bit = n;
    @(posedge clk);
    #5 tx_write = 1'b1;
    tx_data = d;
    @(posedge clk);
    #5 tx_write = 1'b0;
    peer.recv(nb, got, ok);
    check("start bit", 12'(ok), 12'h001);
    check("tx frame", got, fvec(f, p, o, n, d));
    // look just after each edge, never in the edge's own time step
    for (int k = 0; k < 3 * BIT && tx_busy !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    // stop count shows in the busy length; a short frame must fail too
    span = busy_cnt - (1 + nb) * BIT;
    check("busy span", 12'(span >= 0 && span < 6), 12'h001);
    if (w && f == 2'h3) check("oe idle", 12'(serial_transmit_oe), 12'h000);
    $display("tx test done: mode %0d data %h", f, d);
  endtask : tx_chk

  // one character from the peer into the device; eirq 2 skips the count
  task automatic rx_chk(input logic [1:0] f, input logic p, o, w, n, input logic [7:0] d,
                        input logic [11:0] flip, input logic [1:0] eirq,
                        input logic eperr, eferr);
    int k0;
    set_cfg(f, p, o, 1'b0, w);
    k0 = irq_n;
    peer.send(nbits(f, p, 1'b0), fvec(f, p, o, n, d) ^ flip);
    for (int k = 0; k < 2 * BIT && irq_n == k0; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
    if (eirq != 2'h2) check("irq count", 12'(irq_n - k0), 12'(eirq));
    check("rx data", 12'(serial_data_buffer), 12'((f == 2'h1) ? {1'b0, d[6:0]} : d));
    if (f == 2'h3) check("rx ninth", 12'(received_ninth_bit), 12'(n));
    check("parity err", 12'(parity_error), 12'(eperr));
    check("framing err", 12'(framing_error), 12'(eferr));
    $display("rx test done: mode %0d data %h", f, d);
  endtask : rx_chk

  // watchdog, well beyond the length of all tests
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    errors = 0;
    n_checks = 0;
    irq_n = 0;
    busy_cnt = 0;
    rst = 1'b1;
    frame_format_select = 2'h0;
    {parity_enable, odd_parity, stop_bit_length} = 3'h0;
    {wakeup_filter_enable, transmit_ninth_bit, tx_write} = 3'h0;
    tx_data = 8'h00;
    repeat (10) @(posedge clk);
    #5 rst = 1'b0;
    @(posedge clk);
    #1;
    check("reset pin oe", {10'h000, serial_transmit_pin, serial_transmit_oe}, 12'h003);
    check("reset status", {serial_data_buffer, received_ninth_bit, parity_error,
                           framing_error, tx_busy}, 12'h000);
    // mode 00 refuses writes
    @(posedge clk);
    #5 tx_write = 1'b1;
    @(posedge clk);
    #5 tx_write = 1'b0;
    repeat (10) @(posedge clk);
    check("mode0 idle", {10'h000, tx_busy, serial_transmit_pin}, 12'h001);
    $display("reset and mode 0 test done");
    // transmit in 7 and 8-bit formats with every parity choice
    tx_chk(2'h1, 0, 0, 0, 0, 0, 8'hA5);
    tx_chk(2'h1, 1, 0, 1, 0, 0, 8'h35);
    tx_chk(2'h1, 1, 1, 0, 0, 0, 8'h35);
    tx_chk(2'h2, 0, 0, 0, 0, 0, 8'hC3);
    tx_chk(2'h2, 1, 1, 0, 0, 0, 8'h81);
    tx_chk(2'h2, 1, 0, 0, 0, 0, 8'h81);
    // parity_enable stays low in the 9-bit mode tests
    tx_chk(2'h3, 0, 0, 1, 0, 1, 8'h7E);
    tx_chk(2'h3, 0, 0, 0, 0, 0, 8'hFF);
    // receive, good and bad parity, bad stop
    rx_chk(2'h1, 1, 0, 0, 0, 8'hD3, 12'h000, 2'h1, 0, 0);
    // errored characters still raise their interrupt
    rx_chk(2'h1, 1, 0, 0, 0, 8'h53, 12'h080, 2'h1, 1, 0);
    rx_chk(2'h2, 1, 1, 0, 0, 8'h96, 12'h000, 2'h1, 0, 0);
    rx_chk(2'h2, 1, 1, 0, 0, 8'h96, 12'h100, 2'h1, 1, 0);
    rx_chk(2'h2, 0, 0, 0, 0, 8'h3C, 12'h100, 2'h1, 0, 1);
    rx_chk(2'h3, 0, 0, 0, 1, 8'h11, 12'h000, 2'h1, 0, 0);
    rx_chk(2'h3, 0, 0, 1, 1, 8'h35, 12'h000, 2'h1, 0, 0);
    rx_chk(2'h3, 0, 0, 1, 0, 8'h6C, 12'h000, 2'h0, 0, 0);
    rx_chk(2'h3, 0, 0, 0, 0, 8'hC9, 12'h000, 2'h1, 0, 0);
    tx_chk(2'h3, 0, 0, 0, 0, 0, 8'h5A);
    tx_chk(2'h3, 0, 0, 1, 1, 1, 8'h81);
    stop_test();
  end
endmodule : uart_modes_tb
